// ---- incl_cfg.svh ----
// Behaviour
// - one transmit object carries angles and temperature
// - fixed payload: X bytes 0-1, Y 2-3, temp 4
// - remote request answered in every transmission mode
// - cyclic needs nonzero interval and type 254
// - cyclic sends every interval milliseconds while operational
// - type 254 with threshold sends on angle change
// - type 1..240 sends after every nth sync
// - save parameters to storage, restore on command
// - writes act at once except node id, bit rate
`ifndef INCL_CFG_SVH
`define INCL_CFG_SVH

// transmission type codes
`define TT_ASYNC    8'hfe
`define TT_SYNC_MIN 8'h01
`define TT_SYNC_MAX 8'hf0

// timing: one millisecond and one clock period, in nanoseconds
`define MS_NS  1000000
`define CLK_NS 4

// parameter word indices
`define P_TT   3'h0
`define P_INTV 3'h1
`define P_THR  3'h2
`define P_NID  3'h3
`define P_BR   3'h4
`define P_CNT  3'h5

// parameter defaults
`define D_TT   16'h00fe
`define D_INTV 16'h0000
`define D_THR  16'h0000
`define D_NID  16'h0001
`define D_BR   16'h0000

// unused payload bytes 5..7
`define PAD_BYTES 24'h000000

`endif

// ---- incl_pkg.sv ----
package incl_pkg;
	`include "incl_cfg.svh"

	// word held in parameter storage
	typedef logic [15:0] par_word_t;
	// parameter index
	typedef logic [2:0] par_idx_t;

	// scheduler housekeeping states
	typedef enum logic [1:0] {
		ST_BOOT,
		ST_RUN,
		ST_SAVE
	} sched_st_e;

	// manufacturer default of a parameter word
	function automatic par_word_t par_default(input par_idx_t idx);
		unique case (idx)
			`P_TT:   return `D_TT;
			`P_INTV: return `D_INTV;
			`P_THR:  return `D_THR;
			`P_NID:  return `D_NID;
			default: return `D_BR;
		endcase
	endfunction : par_default
endpackage : incl_pkg

// ---- nvm_if.sv ----
`timescale 1ns/1ps
interface nvm_if import incl_pkg::*;;
	logic      we;    // write strobe
	par_idx_t  addr;  // word index
	par_word_t wdata; // word to store
	par_word_t rdata; // registered read word
	modport ctl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface : nvm_if

// ---- param_nvm.sv ----
`timescale 1ns/1ps
`include "incl_cfg.svh"
// small parameter store; read data come from a register one cycle after addr
module param_nvm import incl_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// access port
	nvm_if.mem       port
);
	par_word_t mem_r [`P_CNT]; // stored words

	// writes; reset stands in for factory programming
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < `P_CNT; i++) begin
				mem_r[i] <= par_default(par_idx_t'(i));
			end
		end else if (port.we && port.addr < `P_CNT) begin
			mem_r[port.addr] <= port.wdata;
		end
	end

	// registered read
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			port.rdata <= 16'h0000;
		end else begin
			port.rdata <= (port.addr < `P_CNT) ? mem_r[port.addr] : 16'h0000;
		end
	end
endmodule : param_nvm

// ---- inclinometer_pdo_transmit_scheduler.sv ----
`timescale 1ns/1ps
`include "incl_cfg.svh"
// transmit scheduler for the single process data object
module inclinometer_pdo_transmit_scheduler import incl_pkg::*; #(
	parameter int MS_CYC = `MS_NS / `CLK_NS  // clocks per millisecond
)(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// measurement
	input  wire logic [15:0] x_angle_i,
	input  wire logic [15:0] y_angle_i,
	input  wire logic [7:0]  temp_i,
	input  wire logic        sample_valid_i,
	// network events
	input  wire logic        operational_i,
	input  wire logic        rtr_i,
	input  wire logic        sync_i,
	input  wire logic        reset_comm_i,
	// frame to the can controller
	output logic             frame_valid_o,
	output logic [63:0]      frame_data_o,
	input  wire logic        frame_ready_i,
	// parameter access
	input  wire logic        par_wr_i,
	input  wire logic [2:0]  par_sel_i,
	input  wire logic [15:0] par_wdata_i,
	input  wire logic        store_i,
	input  wire logic        restore_i,
	output logic             busy_o,
	output logic [6:0]       node_id_o,
	output logic [2:0]       bitrate_o
);
	localparam int MSW = $clog2(MS_CYC + 1);

	nvm_if nvm ();                  // storage port
	sched_st_e        st_r;         // housekeeping state
	par_idx_t         idx_r;        // boot/save word index
	logic [7:0]       tt_r;         // transmission type
	logic [15:0]      intv_r;       // cycle interval in ms
	logic [15:0]      thr_r;        // angle change threshold
	logic [6:0]       nid_pend_r;   // node id awaiting comm reset
	logic [2:0]       br_pend_r;    // bit rate awaiting comm reset
	logic [MSW-1:0]   ms_cnt_r;     // clock count within a ms
	logic [15:0]      intv_cnt_r;   // ms count within an interval
	logic [7:0]       sync_cnt_r;   // syncs seen since last nth-sync send
	logic [15:0]      last_x_r;     // x angle last sent
	logic [15:0]      last_y_r;     // y angle last sent
	logic             pend_r;       // a send is owed
	logic             ms_tick;      // one-cycle millisecond strobe
	logic             cyc_en;       // cyclic mode active
	logic             ev_en;        // event mode active
	logic             sync_mode;    // synchronous type 1..240
	logic             cyc_fire;     // interval elapsed
	logic             ev_fire;      // angle moved enough
	logic             sync_fire;    // nth sync arrived
	logic             rtr_fire;     // remote request taken
	logic             take;         // frame accepted by controller
	logic             latch;        // frame being loaded

	// absolute difference of two signed angles
	function automatic logic [15:0] ang_delta(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] d;
		d = {a[15], a} - {b[15], b};
		if (d[16]) begin
			d = 17'h00000 - d;
		end
		return d[15:0];
	endfunction : ang_delta

	param_nvm u_nvm (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.port   (nvm.mem)
	);

	// storage port: write while saving, read index otherwise
	assign nvm.we    = (st_r == ST_SAVE);
	assign nvm.addr  = idx_r;
	always_comb begin
		unique case (idx_r)
			`P_TT:   nvm.wdata = {8'h00, tt_r};
			`P_INTV: nvm.wdata = intv_r;
			`P_THR:  nvm.wdata = thr_r;
			`P_NID:  nvm.wdata = {9'h000, nid_pend_r};
			default: nvm.wdata = {13'h0000, br_pend_r};
		endcase
	end

	// mode decode
	assign cyc_en    = operational_i && tt_r == `TT_ASYNC && intv_r != 16'h0000;
	assign ev_en     = operational_i && tt_r == `TT_ASYNC && thr_r != 16'h0000;
	assign sync_mode = tt_r >= `TT_SYNC_MIN && tt_r <= `TT_SYNC_MAX;
	assign ms_tick   = ms_cnt_r == MSW'(MS_CYC - 1);
	assign cyc_fire  = cyc_en && ms_tick && intv_cnt_r >= intv_r - 16'h0001;
	assign ev_fire   = ev_en && sample_valid_i &&
		(ang_delta(x_angle_i, last_x_r) >= thr_r || ang_delta(y_angle_i, last_y_r) >= thr_r);
	assign sync_fire = operational_i && sync_mode && sync_i &&
		sync_cnt_r == tt_r - 8'h01;
	assign rtr_fire  = operational_i && rtr_i;
	assign take      = frame_valid_o && frame_ready_i;
	assign latch     = pend_r && !frame_valid_o;

	// housekeeping: boot load and save walk
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r  <= ST_BOOT;
			idx_r <= 3'h0;
		end else begin
			unique case (st_r)
				ST_BOOT: begin
					idx_r <= idx_r + 3'h1;
					if (idx_r == `P_CNT) begin
						st_r  <= ST_RUN;
						idx_r <= 3'h0;
					end
				end
				ST_RUN: begin
					if (store_i) begin
						st_r <= ST_SAVE;
					end
				end
				ST_SAVE: begin
					idx_r <= idx_r + 3'h1;
					if (idx_r == `P_CNT - 3'h1) begin
						st_r  <= ST_RUN;
						idx_r <= 3'h0;
					end
				end
			endcase
		end
	end

	// busy flag for software
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			busy_o <= 1'b1;
		end else begin
			busy_o <= (st_r == ST_BOOT && idx_r != `P_CNT) ||
				(st_r == ST_RUN && store_i) ||
				(st_r == ST_SAVE && idx_r != `P_CNT - 3'h1);
		end
	end

	// working parameters: boot load, restore, live writes
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			tt_r       <= 8'(`D_TT);
			intv_r     <= `D_INTV;
			thr_r      <= `D_THR;
			nid_pend_r <= 7'(`D_NID);
			br_pend_r  <= 3'(`D_BR);
			node_id_o  <= 7'(`D_NID);
			bitrate_o  <= 3'(`D_BR);
		end else if (st_r == ST_BOOT) begin
			if (idx_r != 3'h0) begin
				unique case (idx_r - 3'h1)
					`P_TT:   tt_r       <= nvm.rdata[7:0];
					`P_INTV: intv_r     <= nvm.rdata;
					`P_THR:  thr_r      <= nvm.rdata;
					`P_NID:  nid_pend_r <= nvm.rdata[6:0];
					default: br_pend_r  <= nvm.rdata[2:0];
				endcase
			end
			if (idx_r == `P_CNT) begin
				node_id_o <= nid_pend_r;
				bitrate_o <= nvm.rdata[2:0];
			end
		end else if (st_r == ST_RUN) begin
			if (restore_i) begin
				tt_r       <= 8'(`D_TT);
				intv_r     <= `D_INTV;
				thr_r      <= `D_THR;
				nid_pend_r <= 7'(`D_NID);
				br_pend_r  <= 3'(`D_BR);
			end else if (par_wr_i) begin
				unique case (par_sel_i)
					`P_TT:   tt_r       <= par_wdata_i[7:0];
					`P_INTV: intv_r     <= par_wdata_i;
					`P_THR:  thr_r      <= par_wdata_i;
					`P_NID:  nid_pend_r <= par_wdata_i[6:0];
					default: br_pend_r  <= par_wdata_i[2:0];
				endcase
			end
			if (reset_comm_i) begin
				node_id_o <= nid_pend_r;
				bitrate_o <= br_pend_r;
			end
		end
	end

	// millisecond prescaler and interval counter
	always_ff @(posedge mclk_i) begin
		if (rst_i || !cyc_en) begin
			ms_cnt_r   <= '0;
			intv_cnt_r <= 16'h0000;
		end else if (ms_tick) begin
			ms_cnt_r   <= '0;
			intv_cnt_r <= cyc_fire ? 16'h0000 : intv_cnt_r + 16'h0001;
		end else begin
			ms_cnt_r <= ms_cnt_r + MSW'(1);
		end
	end

	// sync counter
	always_ff @(posedge mclk_i) begin
		if (rst_i || !sync_mode) begin
			sync_cnt_r <= 8'h00;
		end else if (sync_fire) begin
			sync_cnt_r <= 8'h00;
		end else if (operational_i && sync_i) begin
			sync_cnt_r <= sync_cnt_r + 8'h01;
		end
	end

	// owed-send flag; a new trigger wins over the frame load
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pend_r <= 1'b0;
		end else if (rtr_fire || cyc_fire || ev_fire || sync_fire) begin
			pend_r <= 1'b1;
		end else if (latch) begin
			pend_r <= 1'b0;
		end
	end

	// frame assembly with fixed mapping, held until accepted
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			frame_valid_o <= 1'b0;
			frame_data_o  <= 64'h0;
			last_x_r      <= 16'h0000;
			last_y_r      <= 16'h0000;
		end else if (latch) begin
			frame_valid_o <= 1'b1;
			frame_data_o  <= {`PAD_BYTES, temp_i, y_angle_i, x_angle_i};
			last_x_r      <= x_angle_i;
			last_y_r      <= y_angle_i;
		end else if (take) begin
			frame_valid_o <= 1'b0;
		end
	end

	// checks
	a_payload_pad: assert property (@(posedge mclk_i) disable iff (rst_i)
		frame_valid_o |-> frame_data_o[63:40] == `PAD_BYTES)
		else $error("unused payload bytes not zero");
	a_payload_map: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(frame_valid_o) |-> frame_data_o[39:0] ==
		{$past(temp_i), $past(y_angle_i), $past(x_angle_i)})
		else $error("payload does not hold sampled angles and temperature");
	a_rtr_answer: assert property (@(posedge mclk_i) disable iff (rst_i)
		rtr_fire && !pend_r && !frame_valid_o |-> ##2 frame_valid_o)
		else $error("remote request not answered in two cycles");
	a_cyc_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		cyc_fire |-> tt_r == `TT_ASYNC && intv_r != 16'h0000)
		else $error("cyclic send without type 254 and interval");
	a_cyc_period: assert property (@(posedge mclk_i) disable iff (rst_i)
		cyc_fire |-> ms_tick && intv_cnt_r + 16'h0001 >= intv_r ##1 intv_cnt_r == 16'h0000)
		else $error("cyclic send off the interval boundary");
	a_event_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
		ev_fire |-> tt_r == `TT_ASYNC && thr_r != 16'h0000 && sample_valid_i)
		else $error("event send outside type 254 with threshold");
	a_sync_nth: assert property (@(posedge mclk_i) disable iff (rst_i)
		sync_fire |=> sync_cnt_r == 8'h00 && pend_r)
		else $error("nth sync did not schedule a send");
	a_save_walk: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_r == ST_RUN && store_i |=> st_r == ST_SAVE && nvm.we ##5 st_r == ST_RUN)
		else $error("save walk did not write all words");
	a_write_live: assert property (@(posedge mclk_i) disable iff (rst_i)
		st_r == ST_RUN && !restore_i && par_wr_i && par_sel_i == `P_THR
		|=> thr_r == $past(par_wdata_i))
		else $error("threshold write not effective at once");
	a_nid_deferred: assert property (@(posedge mclk_i) disable iff (rst_i)
		!reset_comm_i && st_r == ST_RUN |=> $stable(node_id_o))
		else $error("node id changed without comm reset");
	a_either_trig: assert property (@(posedge mclk_i) disable iff (rst_i)
		cyc_fire || ev_fire |=> pend_r)
		else $error("cycle or angle trigger lost");
	c_rtr_frame:  cover property (@(posedge mclk_i) rtr_fire ##[1:4] take);
	c_cyc_frame:  cover property (@(posedge mclk_i) cyc_fire ##[1:4] take);
	c_sync_frame: cover property (@(posedge mclk_i) sync_fire ##[1:4] take);
	c_ev_frame:   cover property (@(posedge mclk_i) ev_fire ##[1:4] take);
endmodule : inclinometer_pdo_transmit_scheduler

// ---- frame_sink.sv ----
`timescale 1ns/1ps
// can controller stand-in: takes offered frames, may stall
module frame_sink (
	// clock
	input  wire logic        mclk_i,
	// frame link
	input  wire logic        valid_i,
	input  wire logic [63:0] data_i,
	input  wire logic        slow_i,
	output logic             ready_o,
	// observation
	output logic [63:0]      got_o,
	output logic [15:0]      cnt_o
);
	// nothing taken before the first edge
	initial begin
		ready_o = 1'b0;
		got_o = 64'h0;
		cnt_o = 16'h0;
	end
	// take a frame when offered and ready; ready moves only after an edge
	always @(posedge mclk_i) begin
		if (valid_i && ready_o) begin
			got_o <= data_i;
			cnt_o <= cnt_o + 16'h1;
		end
		ready_o <= !slow_i;
	end
endmodule : frame_sink

// ---- inclinometer_pdo_transmit_scheduler_bench.sv ----
`timescale 1ns/1ps
// bench for the transmit scheduler, driven on the falling edge
module inclinometer_pdo_transmit_scheduler_bench import incl_pkg::*;;
	logic        mclk_i, rst_i;        // clock and reset
	logic [15:0] x, y;                 // angles
	logic [7:0]  tmp;                  // temperature
	logic [5:0]  ev;                   // rtr sync sample rcomm store restore
	logic        op, slow, fv, fr, wr; // link and write strobes
	logic [2:0]  sel, br;              // parameter select, bit rate
	logic [15:0] wd, cnt;              // write data, frame count
	logic [63:0] fd, got;              // offered and taken frame
	logic        busy;                 // housekeeping busy
	logic [6:0]  nid;                  // active node id
	int          err_count, n_checks;  // tallies
	int          c;                    // scratch count

	inclinometer_pdo_transmit_scheduler #(.MS_CYC(10)) u_inclinometer_pdo_transmit_scheduler (
		.mclk_i(mclk_i), .rst_i(rst_i), .x_angle_i(x), .y_angle_i(y),
		.temp_i(tmp), .sample_valid_i(ev[2]), .operational_i(op), .rtr_i(ev[0]),
		.sync_i(ev[1]), .reset_comm_i(ev[3]), .frame_valid_o(fv),
		.frame_data_o(fd), .frame_ready_i(fr), .par_wr_i(wr), .par_sel_i(sel),
		.par_wdata_i(wd), .store_i(ev[4]), .restore_i(ev[5]), .busy_o(busy),
		.node_id_o(nid), .bitrate_o(br));
	frame_sink u_frame_sink (.mclk_i(mclk_i), .valid_i(fv), .data_i(fd),
		.slow_i(slow), .ready_o(fr), .got_o(got), .cnt_o(cnt));

	// compare and tally
	task chk(input string nm, input logic [63:0] e, input logic [63:0] s);
		n_checks++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			err_count++;
		end
	endtask : chk
	// one-cycle event pulse
	task pulse(input int k);
		@(negedge mclk_i) ev[k] = 1'b1;
		@(negedge mclk_i) ev[k] = 1'b0;
	endtask : pulse
	// one parameter write
	task wpar(input logic [2:0] s, input logic [15:0] d);
		@(negedge mclk_i) begin
			wr = 1'b1; sel = s; wd = d;
		end
		@(negedge mclk_i) wr = 1'b0;
	endtask : wpar
	// frames taken over a span
	task frames(input string nm, input int n, input int lim);
		c = cnt;
		repeat (lim) @(negedge mclk_i);
		chk(nm, n, cnt - 16'(c));
	endtask : frames
	// bounded wait for housekeeping to finish
	task idle;
		for (int i = 0; i < 50 && busy !== 1'b0; i++) @(negedge mclk_i);
		chk("busy", 0, busy);
	endtask : idle
	// verdict
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// free-running clock
	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end
	// hang guard
	initial begin
		#(4 * 6000);
		err_count++;
		close_out();
	end

	// test sequence
	initial begin
		rst_i = 1'b1; x = 16'h1234; y = 16'habcd; tmp = 8'h5a; ev = 6'h0;
		op = 1'b1; slow = 1'b1; wr = 1'b0; sel = 3'h0; wd = 16'h0;
		err_count = 0; n_checks = 0;
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		idle();
		// remote request while the controller stalls: frame must stand
		pulse(0);
		repeat (10) @(negedge mclk_i);
		chk("valid", 1, fv);
		slow = 1'b0;
		frames("rtr", 1, 5);
		chk("data", {24'h0, tmp, y, x}, got);
		$display("test rtr done");
		// not operational: nothing goes out
		op = 1'b0;
		pulse(0);
		frames("offline", 0, 20);
		op = 1'b1;
		$display("test offline done");
		// every third sync, remote request still answered
		wpar(3'h0, 16'h0003);
		pulse(1);
		pulse(1);
		frames("sync2", 0, 10);
		pulse(1);
		frames("sync3", 1, 10);
		pulse(0);
		frames("syncrtr", 1, 10);
		pulse(5);
		for (int i = 0; i < 3; i++) pulse(1);
		frames("restored", 0, 15);
		$display("test sync done");
		// cyclic every 2 ms, off again with a zero interval
		wpar(3'h1, 16'h0002);
		frames("cyclic", 0, 0);
		repeat (100) @(negedge mclk_i);
		chk("cyc", 1, (cnt - 16'(c)) inside {16'h4, 16'h5});
		wpar(3'h1, 16'h0000);
		frames("cycoff", 0, 50);
		$display("test cyclic done");
		// angle change above and below threshold
		wpar(3'h2, 16'h0010);
		x = x + 16'h0020;
		pulse(2);
		frames("moved", 1, 10);
		chk("ev_data", {24'h0, tmp, y, x}, got);
		x = x + 16'h0001;
		pulse(2);
		frames("still", 0, 20);
		$display("test event done");
		// node id waits for reset_comm; store raises busy
		wpar(3'h3, 16'h0005);
		wpar(3'h4, 16'h0003);
		chk("nid_hold", 7'h01, nid);
		chk("br_hold", 3'h0, br);
		pulse(3);
		chk("nid_new", 7'h05, nid);
		chk("br_new", 3'h3, br);
		pulse(4);
		chk("store", 1, busy);
		idle();
		chk("saved", 16'h0010, u_inclinometer_pdo_transmit_scheduler.u_nvm.mem_r[2]);
		$display("test params done");
		close_out();
	end
endmodule : inclinometer_pdo_transmit_scheduler_bench
